// ### include/bert_defines.vh
// Register offsets, field positions, reset values and rate counts of the BERT control block
`ifndef BERT_DEFINES_VH
`define BERT_DEFINES_VH

// Register indices; byte address is four times the index
`define PATTERN_SET_IDX       8'h00
`define PATTERN_LENGTH_IDX    8'h04
`define POLY_TAP_IDX          8'h05
`define PATTERN_CONTROL_IDX   8'h06
`define ERROR_INSERT_IDX      8'h07
`define BIT_TOTAL_IDX         8'h08
`define ERROR_TOTAL_IDX       8'h0c
`define CAPTURED_PATTERN_IDX  8'h10
`define STATUS_IDX            8'h14

// Pattern control fields
`define CTL_TX_PATTERN_LOAD   7
`define CTL_ZERO_SUPPRESS     6
`define CTL_PATTERN_TYPE      5
`define CTL_COUNT_LATCH       4
`define CTL_RECEIVE_CAPTURE   3
`define CTL_AUTO_RESYNC_DIS   2
`define CTL_MANUAL_REALIGN    1
`define CTL_LOOP_BACK         0

// Error insert fields
`define INS_TX_INVERT         5
`define INS_RX_INVERT         4
`define INS_SINGLE_ERROR      3
`define INS_RATE_MSB          2

// Reset values
`define PATTERN_CONTROL_RESET 8'h00
`define ERROR_INSERT_RESET    8'h00
`define PATTERN_SET_RESET     32'hffffffff
`define PATTERN_LENGTH_RESET  5'h1f
`define POLY_TAP_RESET        5'h00

// Zero suppression limit and error rate periods in bits
`define ZERO_RUN_LIMIT        5'd14
`define RATE_PERIOD_1         24'd10
`define RATE_PERIOD_2         24'd100
`define RATE_PERIOD_3         24'd1000
`define RATE_PERIOD_4         24'd10000
`define RATE_PERIOD_5         24'd100000
`define RATE_PERIOD_6         24'd1000000
`define RATE_PERIOD_7         24'd10000000

// Detector synchronisation thresholds
`define SYNC_GOOD_BITS        6'd32
`define SYNC_LOSS_ERRORS      4'd6
`define SYNC_WINDOW_BITS      7'd64

`endif

// ### src/bert_ctrl.v
// BERT pattern control, error insertion, detector and counters behind an APB slave
//
// Contract
// - Zero suppression forces one after fourteen zeros
// - Type bit selects repetitive or pseudorandom pattern
// - Latch edge copies counts, clears internal counts
// - Latch bit ORed with latch pin
// - Capture edge stores last 32 received bits
// - Capture bit ORed with capture pin
// - Resync disable bit stops automatic resynchronisation
// - Realign edge forces detector resynchronisation
// - Transmit invert flips every transmitted bit
// - Receive invert flips every received bit
// - Errors corrupt only the generated transmit pattern
// - Single error edge corrupts exactly one bit
// - Rate code sets periodic error insertion
// - Counters hold while synchronisation is lost
`timescale 1ns/1ps
`default_nettype none
`include "bert_defines.vh"

module bert_ctrl #(
    parameter integer CNT_W = 32
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [7:0]        paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output reg               pslverr,
    input  wire              tx_pattern_load_pin,
    input  wire              count_latch_pin,
    input  wire              receive_capture_pin,
    input  wire              rx_data_pin,
    output reg               tx_data,
    output wire              in_sync
);

    // Register state
    reg  [7:0]       pattern_control_q;
    reg  [7:0]       error_insert_control_q;
    reg  [31:0]      pset_q;
    reg  [4:0]       plen_q;
    reg  [4:0]       ptap_q;
    reg  [CNT_W-1:0] bit_total_q;
    reg  [CNT_W-1:0] error_total_q;
    reg  [31:0]      captured_q;
    // Generator and detector state
    reg  [31:0]      gen_q;
    reg  [4:0]       zero_run_q;
    reg  [23:0]      rate_cnt_q;
    reg              single_pend_q;
    reg  [31:0]      rx_hist_q;
    reg              sync_q;
    reg  [5:0]       good_run_q;
    reg  [6:0]       win_cnt_q;
    reg  [3:0]       win_err_q;
    reg  [CNT_W-1:0] bit_cnt_q;
    reg  [CNT_W-1:0] err_cnt_q;
    // Pin synchronisers and edge history
    reg  [2:0]       pin_s1_q;
    reg  [2:0]       pin_s2_q;
    reg              rx_s1_q;
    reg              rx_s2_q;
    reg  [4:0]       ctl_prev_q;

    wire [7:0] word_idx = {2'b00, paddr[7:2]};
    wire       setup    = psel & ~penable;
    wire       wr_en    = psel & penable & pwrite;

    // Bus answers in one access cycle; read data is prepared in setup
    assign pready  = 1'b1;
    assign in_sync = sync_q;

    // Address decode check
    reg mapped;
    always @* begin
        mapped = 1'b0;
        case (word_idx)
            `PATTERN_SET_IDX, `PATTERN_LENGTH_IDX, `POLY_TAP_IDX,
            `PATTERN_CONTROL_IDX, `ERROR_INSERT_IDX, `BIT_TOTAL_IDX,
            `ERROR_TOTAL_IDX, `CAPTURED_PATTERN_IDX, `STATUS_IDX: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read mux; unused upper bits read as zero
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (word_idx)
            `PATTERN_SET_IDX:      rd_mux = pset_q;
            `PATTERN_LENGTH_IDX:   rd_mux = {27'h0000000, plen_q};
            `POLY_TAP_IDX:         rd_mux = {27'h0000000, ptap_q};
            `PATTERN_CONTROL_IDX:  rd_mux = {24'h000000, pattern_control_q};
            `ERROR_INSERT_IDX:     rd_mux = {24'h000000, error_insert_control_q};
            `BIT_TOTAL_IDX:        rd_mux = bit_total_q[31:0];
            `ERROR_TOTAL_IDX:      rd_mux = error_total_q[31:0];
            `CAPTURED_PATTERN_IDX: rd_mux = captured_q;
            `STATUS_IDX:           rd_mux = {31'h00000000, sync_q};
            default:               rd_mux = 32'h00000000;
        endcase
    end

    // Registered read data and error, valid during the access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= ~mapped;
        end
    end

    // Software registers; unused high bits are dropped on write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pattern_control_q      <= `PATTERN_CONTROL_RESET;
            error_insert_control_q <= `ERROR_INSERT_RESET;
            pset_q                 <= `PATTERN_SET_RESET;
            plen_q                 <= `PATTERN_LENGTH_RESET;
            ptap_q                 <= `POLY_TAP_RESET;
        end else if (wr_en) begin
            case (word_idx)
                `PATTERN_SET_IDX:     pset_q                 <= pwdata;
                `PATTERN_LENGTH_IDX:  plen_q                 <= pwdata[4:0];
                `POLY_TAP_IDX:        ptap_q                 <= pwdata[4:0];
                `PATTERN_CONTROL_IDX: pattern_control_q      <= pwdata[7:0];
                `ERROR_INSERT_IDX:    error_insert_control_q <= {2'b00, pwdata[5:0]};
                default:              pattern_control_q      <= pattern_control_q;
            endcase
        end
    end

    // Two-flop synchronisers on all pins before any logic looks at them
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 3'b000;
            pin_s2_q <= 3'b000;
            rx_s1_q  <= 1'b0;
            rx_s2_q  <= 1'b0;
        end else begin
            pin_s1_q <= {tx_pattern_load_pin, count_latch_pin, receive_capture_pin};
            pin_s2_q <= pin_s1_q;
            rx_s1_q  <= rx_data_pin;
            rx_s2_q  <= rx_s1_q;
        end
    end

    // Combined controls: load, latch, capture, realign, single error
    wire [4:0] ctl_now = {
        pattern_control_q[`CTL_TX_PATTERN_LOAD] | pin_s2_q[2],
        pattern_control_q[`CTL_COUNT_LATCH] | pin_s2_q[1],
        pattern_control_q[`CTL_RECEIVE_CAPTURE] | pin_s2_q[0],
        pattern_control_q[`CTL_MANUAL_REALIGN],
        error_insert_control_q[`INS_SINGLE_ERROR]
    };
    // Only a fresh low-to-high change acts, so a held bit does nothing
    wire [4:0] ctl_rise = ctl_now & ~ctl_prev_q;
    wire load_rise    = ctl_rise[4];
    wire latch_rise   = ctl_rise[3];
    wire capture_rise = ctl_rise[2];
    wire realign_rise = ctl_rise[1];
    wire single_rise  = ctl_rise[0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl_prev_q <= 5'b00000;
        else
            ctl_prev_q <= ctl_now;
    end

    // Generator next bit: feedback for pseudorandom, rotation for repetitive
    wire prbs_mode = pattern_control_q[`CTL_PATTERN_TYPE];
    wire gen_fb    = prbs_mode ? (gen_q[plen_q] ^ gen_q[ptap_q]) : gen_q[plen_q];
    // Suppression looks at the run already sent, so at most fourteen zeros leave
    wire zs_force  = pattern_control_q[`CTL_ZERO_SUPPRESS] && (zero_run_q == `ZERO_RUN_LIMIT);
    wire gen_bit   = gen_fb | zs_force;

    // Period for the selected automatic rate
    reg [23:0] rate_period;
    always @* begin
        case (error_insert_control_q[`INS_RATE_MSB:0])
            3'd1:    rate_period = `RATE_PERIOD_1;
            3'd2:    rate_period = `RATE_PERIOD_2;
            3'd3:    rate_period = `RATE_PERIOD_3;
            3'd4:    rate_period = `RATE_PERIOD_4;
            3'd5:    rate_period = `RATE_PERIOD_5;
            3'd6:    rate_period = `RATE_PERIOD_6;
            3'd7:    rate_period = `RATE_PERIOD_7;
            default: rate_period = 24'h000000;
        endcase
    end
    wire rate_on  = (error_insert_control_q[`INS_RATE_MSB:0] != 3'd0);
    wire rate_hit = rate_on && (rate_cnt_q == rate_period - 24'd1);
    wire err_ins  = rate_hit | single_pend_q;

    // Transmit section: load, shift, error insert, inversion
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_q         <= `PATTERN_SET_RESET;
            zero_run_q    <= 5'd0;
            rate_cnt_q    <= 24'h000000;
            single_pend_q <= 1'b0;
            tx_data       <= 1'b0;
        end else begin
            if (load_rise)
                gen_q <= pset_q;
            else
                gen_q <= {gen_q[30:0], gen_bit};
            // Run follows the bit that leaves, so a reload cannot stretch it; saturates at the limit
            if (gen_bit)
                zero_run_q <= 5'd0;
            else if (zero_run_q != `ZERO_RUN_LIMIT)
                zero_run_q <= zero_run_q + 5'd1;
            if (!rate_on || rate_hit)
                rate_cnt_q <= 24'h000000;
            else
                rate_cnt_q <= rate_cnt_q + 24'd1;
            // A new edge arms one error; the pending bit is spent on the next bit
            if (single_rise)
                single_pend_q <= 1'b1;
            else if (single_pend_q)
                single_pend_q <= 1'b0;
            // Corruption applies to the generated stream only
            tx_data <= (gen_bit ^ err_ins) ^ error_insert_control_q[`INS_TX_INVERT];
        end
    end

    // Receive bit: loopback takes the transmit line, else the synced pin
    wire rx_raw = pattern_control_q[`CTL_LOOP_BACK] ? tx_data : rx_s2_q;
    wire rx_bit = rx_raw ^ error_insert_control_q[`INS_RX_INVERT];
    // Expected bit predicted from received history with the same structure
    wire rx_exp = prbs_mode ? (rx_hist_q[plen_q] ^ rx_hist_q[ptap_q]) : rx_hist_q[plen_q];
    wire rx_err = rx_bit ^ rx_exp;

    // Detector synchronisation
    wire auto_resync = ~pattern_control_q[`CTL_AUTO_RESYNC_DIS];
    wire win_end     = (win_cnt_q == `SYNC_WINDOW_BITS - 7'd1);
    // Errors counted while auto resync was off still count once it is back on
    wire loss_now    = sync_q && auto_resync && rx_err &&
                       (win_err_q >= `SYNC_LOSS_ERRORS - 4'd1);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_hist_q  <= 32'h00000000;
            sync_q     <= 1'b0;
            good_run_q <= 6'd0;
            win_cnt_q  <= 7'd0;
            win_err_q  <= 4'd0;
        end else begin
            rx_hist_q <= {rx_hist_q[30:0], rx_bit};
            if (realign_rise || loss_now) begin
                sync_q     <= 1'b0;
                good_run_q <= 6'd0;
                win_cnt_q  <= 7'd0;
                win_err_q  <= 4'd0;
            end else if (!sync_q) begin
                // Hunting: needs a clean run before declaring sync
                good_run_q <= rx_err ? 6'd0 : good_run_q + 6'd1;
                if (!rx_err && good_run_q == `SYNC_GOOD_BITS - 6'd1)
                    sync_q <= 1'b1;
            end else begin
                win_cnt_q <= win_end ? 7'd0 : win_cnt_q + 7'd1;
                if (win_end)
                    win_err_q <= 4'd0;
                else if (rx_err && win_err_q != 4'hf)
                    win_err_q <= win_err_q + 4'd1;
            end
        end
    end

    // Counters, latch and capture
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q     <= {CNT_W{1'b0}};
            err_cnt_q     <= {CNT_W{1'b0}};
            bit_total_q   <= {CNT_W{1'b0}};
            error_total_q <= {CNT_W{1'b0}};
            captured_q    <= 32'h00000000;
        end else begin
            if (latch_rise) begin
                bit_total_q   <= bit_cnt_q;
                error_total_q <= err_cnt_q;
                bit_cnt_q     <= {CNT_W{1'b0}};
                err_cnt_q     <= {CNT_W{1'b0}};
            end else if (sync_q) begin
                // Out of sync the counts stand still
                bit_cnt_q <= bit_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                if (rx_err)
                    err_cnt_q <= err_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            if (capture_rise)
                captured_q <= rx_hist_q;
        end
    end

endmodule

`default_nettype wire

// ### verification/bert_ctrl_checker.sv
// Concurrent checks on the APB side and detector of the BERT control block
`timescale 1ns/1ps
`default_nettype none
module bert_ctrl_checker #(
    parameter integer CNT_W = 32
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_pattern_load_pin,
    input wire logic        count_latch_pin,
    input wire logic        receive_capture_pin,
    input wire logic        rx_data_pin,
    input wire logic        tx_data,
    input wire logic        in_sync
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [5:0] idx;
    logic       mapped;
    logic [7:0] ctl_shadow_q;
    logic [5:0] ins_shadow_q;
    // Word index and decoded words
    assign idx = paddr[7:2];
    assign mapped = idx inside {6'h00, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0c, 6'h10, 6'h14};
    // Shadow of the control words as last written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_shadow_q <= 8'h00;
            ins_shadow_q <= 6'h00;
        end else if (psel && penable && pwrite && idx == 6'h06) begin
            ctl_shadow_q <= pwdata[7:0];
        end else if (psel && penable && pwrite && idx == 6'h07) begin
            ins_shadow_q <= pwdata[5:0];
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence read_s;
        psel && penable && !pwrite;
    endsequence
    ready_always_a: assert property (pready) else $error("ready low");
    unmapped_err_a: assert property ((psel && penable && !mapped) |-> pslverr && prdata == 32'h0)
        else $error("unmapped word accepted");
    mapped_ok_a: assert property ((psel && penable && mapped) |-> !pslverr) else $error("mapped word refused");
    pcr_readback_a: assert property (read_s ##0 idx == 6'h06 |-> prdata == {24'h0, ctl_shadow_q})
        else $error("control word mismatch");
    eir_readback_a: assert property (read_s ##0 idx == 6'h07 |-> prdata == {26'h0, ins_shadow_q})
        else $error("insert word mismatch");
    prdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    status_sync_a: assert property (read_s ##0 idx == 6'h14 |-> prdata == {31'h0, $past(in_sync)})
        else $error("status word mismatch");
    realign_drop_a: assert property ($rose(ctl_shadow_q[1]) |-> ##[0:4] !in_sync)
        else $error("realign kept sync");
endmodule
bind bert_ctrl bert_ctrl_checker #(.CNT_W(CNT_W)) bert_ctrl_checker_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_pattern_load_pin(tx_pattern_load_pin),
    .count_latch_pin(count_latch_pin), .receive_capture_pin(receive_capture_pin),
    .rx_data_pin(rx_data_pin), .tx_data(tx_data), .in_sync(in_sync));
`default_nettype wire

// ### verification/line_model.sv
// Line under test: carries transmit data back to the receive pin
`timescale 1ns/1ps
`default_nettype none
module line_model #(
    parameter int DELAY = 3
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic tx_data,
    output var  logic rx_data_pin
);
    logic [DELAY-1:0] pipe_q;
    // Line latency; raise DELAY for a slow path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pipe_q <= {DELAY{1'b0}};
        else pipe_q <= {pipe_q[DELAY-2:0], tx_data};
    end
    assign rx_data_pin = pipe_q[DELAY-1];
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the BERT control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd, pwd;
    logic [2:0]  pins;
    wire  [31:0] prdata;
    wire         pready, pslverr, rxd, txd, ins;
    int          err_total, n_compared, seed, z, mr, i;
    bert_ctrl bert_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_pattern_load_pin(pins[0]), .count_latch_pin(pins[1]),
        .receive_capture_pin(pins[2]), .rx_data_pin(rxd), .tx_data(txd), .in_sync(ins));
    line_model line_model_i (.pclk(pclk), .presetn(presetn), .tx_data(txd), .rx_data_pin(rxd));
    // Errors expected in a window for a rate code
    function automatic int errs_in(input int c, input int win);
        return (c == 0) ? 0 : win / (10 ** c);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Pulse a control pin long enough for its synchroniser
    task automatic pulse(input int k);
        pins[k] <= 1'b1;
        repeat (4) @(posedge pclk);
        pins[k] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // Zeros and longest zero run on the transmit pin
    task automatic watch(input int n);
        int run;
        z = 0;
        mr = 0;
        run = 0;
        repeat (n) begin
            @(posedge pclk);
            run = (txd === 1'b0) ? run + 1 : 0;
            z += (txd === 1'b0);
            mr = (run > mr) ? run : mr;
        end
    endtask
    task automatic wsync(input logic lv, input int n);
        for (int k = 0; k < n && ins !== lv; k++) @(posedge pclk);
        chk("in_sync", {31'h0, lv}, {31'h0, ins});
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        tally_and_finish;
    end
    initial begin
        {err_total, n_compared, seed} = {32'h0, 32'h0, 32'h595d};
        {presetn, psel, penable, pwrite, paddr, pwdata, pins} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("pattern_control", 8'h18, 32'h0);
        rdc("error_insert", 8'h1c, 32'h0);
        rdc("unmapped", 8'h0c, 32'h0);
        chk("pslverr", 32'h1, er);
        repeat (4) begin
            pwd = $random(seed);
            apb(1'b1, 8'h00, pwd);
            rdc("pattern_set", 8'h00, pwd);
        end
        apb(1'b1, 8'h00, 32'hffffffff);
        apb(1'b1, 8'h10, 32'h0);
        pulse(0);
        watch(32);
        chk("zeros", 32'h0, z);
        wsync(1'b1, 300);
        pulse(2);
        rdc("captured", 8'h40, 32'hffffffff);
        apb(1'b1, 8'h18, 32'h10);
        apb(1'b1, 8'h18, 32'h00);
        repeat (50) @(posedge pclk);
        pulse(1);
        apb(1'b0, 8'h20, 32'h0);
        chk("bit_total", 32'h1, rd >= 40 && rd <= 90);
        rdc("error_total", 8'h30, 32'h0);
        apb(1'b1, 8'h1c, 32'h20);
        repeat (4) @(posedge pclk);
        watch(32);
        chk("zeros", 32'd32, z);
        for (i = 0; i < 3; i++) begin
            apb(1'b1, 8'h1c, i[0] ? 32'h08 : 32'h00);
            watch(40);
            chk("zeros", i[0], z);
        end
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 8'h1c, i);
            repeat (20) @(posedge pclk);
            watch(10 ** (i + 1));
            chk("errors", errs_in(i, 10 ** (i + 1)), z);
        end
        apb(1'b1, 8'h1c, 32'h0);
        // Suppression works in either pattern type, tried here with the quasi-random polynomial; all-zero seed gives a quick long run
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h10, 32'h13);
        apb(1'b1, 8'h14, 32'h10);
        apb(1'b1, 8'h18, 32'he0);
        apb(1'b1, 8'h18, 32'h60);
        watch(100);
        chk("zero_run", 32'd14, mr);
        apb(1'b1, 8'h00, 32'hffffffff);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h10, 32'h06);
        apb(1'b1, 8'h18, 32'ha0);
        apb(1'b1, 8'h18, 32'h20);
        watch(64);
        chk("prbs_zeros", 32'h1, z > 0);
        wsync(1'b1, 300);
        rdc("status", 8'h50, 32'h1);
        apb(1'b1, 8'h1c, 32'h10);
        wsync(1'b0, 300);
        pulse(1);
        repeat (50) @(posedge pclk);
        pulse(1);
        rdc("bit_total", 8'h20, 32'h0);
        apb(1'b1, 8'h1c, 32'h0);
        wsync(1'b1, 300);
        apb(1'b1, 8'h18, 32'h24);
        apb(1'b1, 8'h1c, 32'h10);
        repeat (200) @(posedge pclk);
        chk("in_sync", 32'h1, ins);
        apb(1'b1, 8'h18, 32'h26);
        wsync(1'b0, 10);
        tally_and_finish;
    end
endmodule
`default_nettype wire
